// file: hw/fps_status_top.sv
`timescale 1ns/1ps
// How it works
// R1 - Status byte readable anytime, repeats while selected.
// R2 - Opcode takes eight SPI or two quad clocks.
// R3 - Host sets write enable before status write.
// R4 - Status write sets OTP lockdown, never undone.
// R5 - Writes execute only if select rises byte-aligned.
// R6 - Erase fail flag sets/clears by erase result.
// R7 - Program fail flag sets/clears by program result.
// R8 - Erase suspend flag set on suspend, cleared resume.
// R9 - Program suspend flag set on suspend, cleared resume.
// R10 - Bit zero reports factory lock of OTP.
// R11 - Secured OTP mode blocks main array access.
// R12 - Flags and reserved bit volatile, reset zero.
// R13 - Scheme bit picks level or per-sector protection.
// R14 - Select command sets scheme bit, never clears.
// R15 - Scheme zero protects by block protect level.
// R16 - Scheme one ignores levels, enables lock commands.
// R17 - Volatile locks all set after power-up.
// R18 - Low write-protect pin protects every region in scheme one.
// R19 - One lock pair per edge sector, inner block.
// R20 - Either lock bit set inhibits program/erase.
// R21 - Host sends select opcode alone between selects.
// R22 - Persistent locks stay changeable after reset.
// R23 - Freeze bit zero ignores persistent lock changes.
// R24 - Lock reads answer 00h clear, FFh set.
// R25 - Status write alters only the lockdown bit.
module fps_status_top #(
  parameter int         ADDR_W           = 24,
  parameter logic [7:0] OP_WRITE_ENABLE  = 8'h10,
  parameter logic [7:0] OP_READ_STATUS   = 8'h11,
  parameter logic [7:0] OP_WRITE_STATUS  = 8'h12,
  parameter logic [7:0] OP_SCHEME_SELECT = 8'h13,
  parameter logic [7:0] OP_LOCK_REG_WR   = 8'h14,
  parameter logic [7:0] OP_LOCK_REG_RD   = 8'h15,
  parameter logic [7:0] OP_PERSIST_PROG  = 8'h16,
  parameter logic [7:0] OP_PERSIST_ERASE = 8'h17,
  parameter logic [7:0] OP_PERSIST_READ  = 8'h18,
  parameter logic [7:0] OP_VOLATILE_WR   = 8'h19,
  parameter logic [7:0] OP_VOLATILE_RD   = 8'h1A,
  parameter logic [7:0] OP_GLOBAL_LOCK   = 8'h7E,
  parameter logic [7:0] OP_GLOBAL_UNLOCK = 8'h98
) (
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  input  wire logic              link_clk_i,
  input  wire logic              cs_n_i,
  input  wire logic [3:0]        io_i,
  output logic      [3:0]        io_o,
  output logic      [3:0]        io_oe_o,
  input  wire logic              write_protect_n_i,
  input  wire logic              quad_mode_i,
  input  wire logic              factory_otp_lock_i,
  input  wire logic              otp_mode_i,
  input  wire logic [3:0]        block_protect_level_i,
  input  wire logic              erase_result_valid_i,
  input  wire logic              erase_failed_i,
  input  wire logic              program_result_valid_i,
  input  wire logic              program_failed_i,
  input  wire logic              erase_suspend_i,
  input  wire logic              erase_resume_i,
  input  wire logic              program_suspend_i,
  input  wire logic              program_resume_i,
  input  wire logic [ADDR_W-1:0] query_addr_i,
  output logic                   query_protected_o,
  output logic                   array_access_ok_o,
  output logic                   otp_area1_writable_o,
  output logic                   write_enable_latch_o,
  output logic      [7:0]        status_o
);

  // ----------------------------------------------------------------------
  // Region geometry
  // ----------------------------------------------------------------------
  localparam int NUM_BLOCKS  = 2 ** (ADDR_W - fps_pkg::BLOCK_SHIFT);
  localparam int NUM_REGIONS = NUM_BLOCKS - 2 + 2 * fps_pkg::SECTORS;
  localparam int REG_W       = $clog2(NUM_REGIONS);

  // Three address bytes carry the whole address and at least four blocks must exist.
  if (ADDR_W < fps_pkg::BLOCK_SHIFT + 2 || ADDR_W > fps_pkg::ADDR_BYTES * fps_pkg::BYTE_W) begin : g_bad_addr
    $error("ADDR_W must lie between 18 and 24");
  end

  // Maps a byte address to its lock region: bottom sectors first, then inner blocks, then top sectors.
  function automatic logic [REG_W-1:0] region_of(input logic [ADDR_W-1:0] a);
    int blk;
    int sec;
    int idx;
    blk = int'(a[ADDR_W-1:fps_pkg::BLOCK_SHIFT]);
    sec = int'(a[fps_pkg::BLOCK_SHIFT-1:fps_pkg::SECTOR_SHIFT]);
    if (blk == 0) begin
      idx = sec;
    end else if (blk == NUM_BLOCKS - 1) begin
      idx = fps_pkg::SECTORS + NUM_BLOCKS - 2 + sec;
    end else begin
      idx = fps_pkg::SECTORS + blk - 1;
    end
    return REG_W'(idx); // R19
  endfunction

  // Level scheme: level n protects the top 2^(n-1) blocks, level 0 nothing.
  function automatic logic bp_protects(input logic [3:0] lvl, input logic [ADDR_W-1:0] a);
    int blk;
    int span;
    blk = int'(a[ADDR_W-1:fps_pkg::BLOCK_SHIFT]);
    if (lvl == 4'h0) begin
      return 1'b0;
    end
    span = (int'(lvl) > ADDR_W - fps_pkg::BLOCK_SHIFT) ? NUM_BLOCKS : (1 << (int'(lvl) - 1));
    return blk >= NUM_BLOCKS - span; // R15
  endfunction

  // Address of a captured frame, most significant byte first.
  function automatic logic [ADDR_W-1:0] frame_addr(input fps_pkg::fps_link_t f);
    logic [fps_pkg::ADDR_BYTES*fps_pkg::BYTE_W-1:0] full;
    full = {f.bytes[1], f.bytes[2], f.bytes[3]};
    return full[ADDR_W-1:0];
  endfunction

  fps_pkg::fps_link_t     link_reg;
  fps_pkg::fps_link_t     link_next;
  fps_pkg::fps_sys_t      sys_reg;
  fps_pkg::fps_sys_t      sys_next;
  logic [NUM_REGIONS-1:0] persist_reg;
  logic [NUM_REGIONS-1:0] persist_next;
  logic [NUM_REGIONS-1:0] volatile_reg;
  logic [NUM_REGIONS-1:0] volatile_next;
  logic                   new_frame_reg;
  logic [3:0]             oe_reg;
  logic [3:0]             oe_next;
  logic                   frame_rst;
  logic [7:0]             status_vec;

  // ----------------------------------------------------------------------
  // Link domain: shift in opcode, address and data, shift out answers
  // ----------------------------------------------------------------------

  // The link clock stops between frames, so the frame's end is seen by the system side
  // and the first edge of the next frame restarts the counters instead.
  always_comb begin
    logic [2:0] bc;
    logic [2:0] nb;
    logic [2:0] nb_inc;
    logic       quad;
    logic       done;
    logic [7:0] op;
    logic       en;
    bc        = new_frame_reg ? 3'h0 : link_reg.bitcnt;
    nb        = new_frame_reg ? 3'h0 : link_reg.nbytes;
    quad      = new_frame_reg ? link_reg.quad_s2 : link_reg.quad_frame;
    link_next = link_reg;
    oe_next   = oe_reg;
    en        = 1'b0;
    link_next.quad_s1    = quad_mode_i;
    link_next.quad_s2    = link_reg.quad_s1;
    link_next.st_s1      = status_vec;
    link_next.st_s2      = link_reg.st_s1;
    link_next.lr_s1      = sys_reg.lr;
    link_next.lr_s2      = link_reg.lr_s1;
    link_next.lk_s1      = sys_reg.lk_bit;
    link_next.lk_s2      = link_reg.lk_s1;
    link_next.quad_frame = quad;
    if (new_frame_reg) begin
      link_next.addr_done = 1'b0;
    end
    // Upper lines are ignored in SPI mode.
    link_next.sh     = quad ? {link_reg.sh[3:0], io_i} : {link_reg.sh[6:0], io_i[0]}; // R2
    link_next.bitcnt = bc + (quad ? fps_pkg::STEP_QUAD : fps_pkg::STEP_SPI); // R2
    link_next.nbytes = nb;
    done   = (link_next.bitcnt == 3'h0);
    nb_inc = (nb == fps_pkg::CNT_MAX) ? nb : nb + 3'h1;
    op     = (nb == 3'h0) ? link_next.sh : link_reg.bytes[0];
    if (done) begin
      if (int'(nb) < fps_pkg::FRAME_BYTES) begin
        link_next.bytes[nb] = link_next.sh;
      end
      link_next.nbytes = nb_inc;
      if (nb_inc >= fps_pkg::CNT_ADDR && (op == OP_PERSIST_READ || op == OP_VOLATILE_RD)) begin
        link_next.addr_done = 1'b1;
      end
      // Each completed byte chooses what the next byte carries.
      if (op == OP_READ_STATUS) begin
        link_next.out = link_reg.st_s2; // R1
        en            = 1'b1;
      end else if (op == OP_LOCK_REG_RD && nb_inc <= 3'h2) begin
        link_next.out = (nb_inc == 3'h1) ? link_reg.lr_s2[7:0] : link_reg.lr_s2[15:8]; // R16
        en            = 1'b1;
      end else if ((op == OP_PERSIST_READ || op == OP_VOLATILE_RD) && nb_inc >= fps_pkg::CNT_ADDR) begin
        link_next.out = link_reg.lk_s2 ? fps_pkg::LOCK_SET : fps_pkg::LOCK_CLEAR; // R24
        en            = 1'b1;
      end else begin
        link_next.out = 8'h00;
      end
      oe_next = en ? (quad ? 4'hF : 4'h2) : 4'h0;
    end else begin
      link_next.out = quad ? {link_reg.out[3:0], 4'h0} : {link_reg.out[6:0], 1'b0};
      if (new_frame_reg) begin
        oe_next = 4'h0;
      end
    end
    link_next.io = quad ? link_next.out[7:4] : {2'b00, link_next.out[7], 1'b0};
  end

  // Frame state survives the select rising so the system side can read it.
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // Raising select releases the data lines at once and marks the next edge as a frame start.
  assign frame_rst = cs_n_i | ~arst_n_i;

  always_ff @(posedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      new_frame_reg <= 1'b1;
      oe_reg        <= 4'h0;
    end else begin
      new_frame_reg <= 1'b0;
      oe_reg        <= oe_next;
    end
  end

  assign io_o    = link_reg.io;
  assign io_oe_o = oe_reg;

  // ----------------------------------------------------------------------
  // System domain: flags, lock bits, command execution at frame end
  // ----------------------------------------------------------------------
  assign status_vec = {sys_reg.scheme, sys_reg.efail, sys_reg.pfail, 1'b0,
                       sys_reg.esusp, sys_reg.psusp, sys_reg.otp_lockdown_bit, sys_reg.fact_s2}; // R10 R12

  // Commands in the captured bytes execute only once the synchronised select shows the frame is over,
  // when the link clock has stopped and the capture is stable.
  always_comb begin
    logic              aligned;
    logic [2:0]        cnt;
    logic [7:0]        op;
    logic [REG_W-1:0]  fr;
    logic [REG_W-1:0]  qr;
    logic              wr;
    logic              sector_on;
    sys_next      = sys_reg;
    persist_next  = persist_reg;
    volatile_next = volatile_reg;
    aligned   = (link_reg.bitcnt == 3'h0);
    cnt       = link_reg.nbytes;
    op        = link_reg.bytes[0];
    fr        = region_of(frame_addr(link_reg));
    qr        = region_of(query_addr_i);
    wr        = 1'b0;
    sector_on = sys_reg.scheme;
    sys_next.cs_s1   = cs_n_i;
    sys_next.cs_s2   = sys_reg.cs_s1;
    sys_next.wp_s1   = write_protect_n_i;
    sys_next.wp_s2   = sys_reg.wp_s1;
    sys_next.fact_s1 = factory_otp_lock_i;
    sys_next.fact_s2 = sys_reg.fact_s1; // R10
    sys_next.ad_s1   = link_reg.addr_done;
    sys_next.ad_s2   = sys_reg.ad_s1;

    // Results and suspend events from the array engine; a set beats a clear in the same cycle.
    if (erase_result_valid_i) begin
      sys_next.efail = erase_failed_i; // R6
    end
    if (program_result_valid_i) begin
      sys_next.pfail = program_failed_i; // R7
    end
    if (erase_suspend_i) begin
      sys_next.esusp = 1'b1; // R8
    end else if (erase_resume_i) begin
      sys_next.esusp = 1'b0; // R8
    end
    if (program_suspend_i) begin
      sys_next.psusp = 1'b1; // R9
    end else if (program_resume_i) begin
      sys_next.psusp = 1'b0; // R9
    end

    case (sys_reg.state)
      fps_pkg::FPS_IDLE: begin
        if (!sys_reg.cs_s2) begin
          sys_next.state = fps_pkg::FPS_ACTIVE;
        end
      end
      fps_pkg::FPS_ACTIVE: begin
        // Look up the addressed lock bit for a read while the frame is still running.
        if (sys_reg.ad_s2) begin
          sys_next.lk_bit = (op == OP_VOLATILE_RD) ? volatile_reg[fr] : persist_reg[fr]; // R24
        end
        if (sys_reg.cs_s2) begin
          sys_next.state = fps_pkg::FPS_EXEC;
        end
      end
      fps_pkg::FPS_EXEC: begin
        sys_next.state = fps_pkg::FPS_IDLE;
        // A frame that stops mid-byte executes nothing.
        if (aligned && cnt != 3'h0) begin // R5
          if (op == OP_WRITE_ENABLE && cnt == fps_pkg::CNT_OP) begin
            sys_next.write_enable_latch = 1'b1;
          end else if (sys_reg.write_enable_latch) begin // R3
            if (op == OP_WRITE_STATUS && cnt == fps_pkg::CNT_OP) begin
              sys_next.otp_lockdown_bit = 1'b1; // R4 R25
              wr            = 1'b1;
            end else if (op == OP_SCHEME_SELECT && cnt == fps_pkg::CNT_OP) begin
              sys_next.scheme = 1'b1; // R14
              wr              = 1'b1;
            end else if (sector_on && op == OP_GLOBAL_LOCK && cnt == fps_pkg::CNT_OP) begin
              volatile_next = '1; // R16
              wr            = 1'b1;
            end else if (sector_on && op == OP_GLOBAL_UNLOCK && cnt == fps_pkg::CNT_OP) begin
              volatile_next = '0; // R16
              wr            = 1'b1;
            end else if (sector_on && op == OP_VOLATILE_WR && cnt == fps_pkg::CNT_VOL_WR) begin
              volatile_next[fr] = |link_reg.bytes[4]; // R16
              wr                = 1'b1;
            end else if (sector_on && op == OP_LOCK_REG_WR && cnt == fps_pkg::CNT_LR_WR) begin
              // One-time bits only ever fall, so a cleared freeze bit stays cleared.
              sys_next.lr = sys_reg.lr & {link_reg.bytes[2], link_reg.bytes[1]};
              wr          = 1'b1;
            end else if (sector_on && op == OP_PERSIST_ERASE && cnt == fps_pkg::CNT_OP) begin
              if (sys_reg.lr[fps_pkg::LR_FREEZE]) begin // R23
                persist_next = '0; // R22
              end
              wr = 1'b1;
            end else if (sector_on && op == OP_PERSIST_PROG && cnt == fps_pkg::CNT_ADDR) begin
              if (sys_reg.lr[fps_pkg::LR_FREEZE]) begin // R23
                persist_next[fr] = 1'b1; // R22
              end
              wr = 1'b1;
            end
          end
        end
        if (wr) begin
          sys_next.write_enable_latch = 1'b0;
        end
      end
      default: begin
        sys_next.state = fps_pkg::FPS_IDLE;
      end
    endcase

    // Protection answer for the array engine, one cycle after the address.
    if (sector_on) begin
      sys_next.qprot = !sys_reg.wp_s2 || persist_reg[qr] || volatile_reg[qr]; // R13 R18 R20
    end else begin
      sys_next.qprot = bp_protects(block_protect_level_i, query_addr_i); // R13 R15
    end
    sys_next.arr_ok = !otp_mode_i; // R11
    sys_next.otp_ok = !sys_reg.otp_lockdown_bit; // R4
  end

  // Non-volatile bits come up at their factory values; a real part would load them from the array.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sys_reg       <= '0; // R12
      sys_reg.lr    <= fps_pkg::LR_RESET;
      sys_reg.state <= fps_pkg::FPS_IDLE;
      sys_reg.cs_s1 <= 1'b1;
      sys_reg.cs_s2 <= 1'b1;
      sys_reg.otp_ok <= 1'b1;
      persist_reg   <= '0; // R22
      volatile_reg  <= '1; // R17
    end else begin
      sys_reg      <= sys_next;
      persist_reg  <= persist_next;
      volatile_reg <= volatile_next;
    end
  end

  assign query_protected_o    = sys_reg.qprot;
  assign array_access_ok_o    = sys_reg.arr_ok;
  assign otp_area1_writable_o = sys_reg.otp_ok;
  assign write_enable_latch_o = sys_reg.write_enable_latch;
  assign status_o             = status_vec;

endmodule

// file: hw/fps_pkg.sv
package fps_pkg;

  // ----------------------------------------------------------------------
  // Widths and frame capture
  // ----------------------------------------------------------------------
  localparam int BYTE_W      = 8;
  localparam int FRAME_BYTES = 6;   // Opcode, three address bytes, two data bytes.
  localparam int CNT_W       = 3;
  localparam int LR_W        = 16;

  // ----------------------------------------------------------------------
  // Protection/status byte layout
  // ----------------------------------------------------------------------
  localparam int ST_SCHEME = 7;
  localparam int ST_EFAIL  = 6;
  localparam int ST_PFAIL  = 5;
  localparam int ST_RSVD   = 4;
  localparam int ST_ESUSP  = 3;
  localparam int ST_PSUSP  = 2;
  localparam int ST_OTP_LOCKDOWN_BIT   = 1;
  localparam int ST_FACT   = 0;

  // ----------------------------------------------------------------------
  // Lock register and lock read answers
  // ----------------------------------------------------------------------
  localparam int             LR_FREEZE   = 6;
  localparam logic [15:0]    LR_RESET    = 16'hFFFF;
  localparam logic [7:0]     LOCK_SET    = 8'hFF;
  localparam logic [7:0]     LOCK_CLEAR  = 8'h00;

  // ----------------------------------------------------------------------
  // Address map of the lock regions
  // ----------------------------------------------------------------------
  localparam int SECTOR_SHIFT = 12;
  localparam int BLOCK_SHIFT  = 16;
  localparam int SECTORS      = 16;    // 4KB sectors in one 64KB block.
  localparam int ADDR_BYTES   = 3;

  // ----------------------------------------------------------------------
  // Bit steps per link clock and frame byte counts
  // ----------------------------------------------------------------------
  localparam logic [2:0] STEP_SPI   = 3'h1;
  localparam logic [2:0] STEP_QUAD  = 3'h4;
  localparam logic [2:0] CNT_OP     = 3'h1;
  localparam logic [2:0] CNT_ADDR   = 3'h4;
  localparam logic [2:0] CNT_LR_WR  = 3'h3;
  localparam logic [2:0] CNT_VOL_WR = 3'h5;
  localparam logic [2:0] CNT_MAX    = 3'h7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FPS_IDLE   = 2'h0,
    FPS_ACTIVE = 2'h1,
    FPS_EXEC   = 2'h3
  } fps_state_t;

  typedef struct packed {
    logic [BYTE_W-1:0]                  sh;
    logic [CNT_W-1:0]                   bitcnt;
    logic [CNT_W-1:0]                   nbytes;
    logic [FRAME_BYTES-1:0][BYTE_W-1:0] bytes;
    logic                               quad_frame;
    logic                               addr_done;
    logic [BYTE_W-1:0]                  out;
    logic [3:0]                         io;
    logic                               quad_s1;
    logic                               quad_s2;
    logic [BYTE_W-1:0]                  st_s1;
    logic [BYTE_W-1:0]                  st_s2;
    logic [LR_W-1:0]                    lr_s1;
    logic [LR_W-1:0]                    lr_s2;
    logic                               lk_s1;
    logic                               lk_s2;
  } fps_link_t;

  typedef struct packed {
    fps_state_t      state;
    logic            cs_s1;
    logic            cs_s2;
    logic            wp_s1;
    logic            wp_s2;
    logic            fact_s1;
    logic            fact_s2;
    logic            ad_s1;
    logic            ad_s2;
    logic            scheme;
    logic            efail;
    logic            pfail;
    logic            esusp;
    logic            psusp;
    logic            otp_lockdown_bit;
    logic            write_enable_latch;
    logic [LR_W-1:0] lr;
    logic            lk_bit;
    logic            qprot;
    logic            arr_ok;
    logic            otp_ok;
  } fps_sys_t;

endpackage

// file: sim/fps_status_top_asserts.sv
`timescale 1ns/1ps
module fps_status_top_asserts (
  input wire logic       clk_sys_i,
  input wire logic       arst_n_i,
  input wire logic       write_protect_n_i,
  input wire logic       otp_mode_i,
  input wire logic       erase_result_valid_i,
  input wire logic       erase_failed_i,
  input wire logic       program_result_valid_i,
  input wire logic       program_failed_i,
  input wire logic       erase_suspend_i,
  input wire logic       erase_resume_i,
  input wire logic       program_suspend_i,
  input wire logic       program_resume_i,
  input wire logic       query_protected_o,
  input wire logic       array_access_ok_o,
  input wire logic [7:0] status_o
);
  // ----------------------------------------------------------------------
  // Status flags and protection outputs
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // Engine results land on the flag one edge later; a set beats a clear.
  efail_tracks_a: assert property (erase_result_valid_i |=> status_o[6] == $past(erase_failed_i))
    else $error("erase fail flag wrong");
  pfail_tracks_a: assert property (program_result_valid_i |=> status_o[5] == $past(program_failed_i))
    else $error("program fail flag wrong");
  esusp_flag_a: assert property (erase_suspend_i || erase_resume_i |=> status_o[3] == $past(erase_suspend_i))
    else $error("erase suspend flag wrong");
  psusp_flag_a: assert property (program_suspend_i || program_resume_i |=> status_o[2] == $past(program_suspend_i))
    else $error("program suspend flag wrong");
  // One-time bits may only ever rise.
  lockdown_sticky_a: assert property (status_o[1] |=> status_o[1])
    else $error("lockdown bit fell");
  scheme_sticky_a: assert property (status_o[7] |=> status_o[7])
    else $error("scheme bit fell");
  reserved_zero_a: assert property (status_o[4] == 1'b0)
    else $error("reserved bit set");
  otp_blocks_array_a: assert property (otp_mode_i [*3] |-> !array_access_ok_o)
    else $error("array open in otp mode");
  // The pin is synchronised first, so it is held a few edges before the query answers.
  wp_pin_protect_a: assert property ((status_o[7] && !write_protect_n_i) [*4] |=> query_protected_o)
    else $error("region open with pin low");
endmodule

bind fps_status_top fps_status_top_asserts chk_u (.clk_sys_i, .arst_n_i, .write_protect_n_i, .otp_mode_i,
  .erase_result_valid_i, .erase_failed_i, .program_result_valid_i, .program_failed_i, .erase_suspend_i,
  .erase_resume_i, .program_suspend_i, .program_resume_i, .query_protected_o, .array_access_ok_o, .status_o);

// file: sim/fps_host_model.sv
`timescale 1ns/1ps
module fps_host_model (
  output logic            link_clk_o,
  output logic            cs_n_o,
  output logic      [3:0] io_o,
  input  wire logic [3:0] io_i
);
  // ----------------------------------------------------------------------
  // Serial host; its clock runs only inside frames
  // ----------------------------------------------------------------------
  initial begin
    link_clk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
  end
  // Data moves on the low half; answers are taken just before each rising edge.
  task automatic xfer(input logic qd, input int nb, input logic [47:0] tx, output logic [47:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    for (int k = 0; k < nb; k += (qd ? 4 : 1)) begin
      if (qd) begin
        io_o = tx[47-k -: 4];
      end else begin
        io_o = {~io_o[3:1], tx[47-k]};
      end
      #80;
      if (qd) begin
        rx[47-k -: 4] = io_i;
      end else begin
        rx[47-k] = io_i[1];
      end
      link_clk_o = 1'b1;
      #80 link_clk_o = 1'b0;
    end
    #80 cs_n_o = 1'b1;
    io_o = ~io_o;
    #600;
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------------
  // Signals, opcodes (the design's defaults) and instances
  // ----------------------------------------------------------------------
  localparam logic [7:0] WE = 8'h10, RS = 8'h11, WS = 8'h12, SL = 8'h13, LW = 8'h14;
  localparam logic [7:0] PP = 8'h16, PE = 8'h17, PR = 8'h18, VW = 8'h19, VR = 8'h1A;
  logic        clk_sys, arst_n, lclk, cs_n, wp_n, quad, otp, qp, aok, otpw, write_enable_latch;
  logic [3:0]  h_io, d_io, d_oe, lvl;
  logic        fact;
  logic [7:0]  ev, st;
  logic [23:0] qa;
  logic [47:0] rx;
  logic [15:0] evt [10];
  int          num_errors, total_checks, cyc;
  fps_status_top dut_u (.clk_sys_i(clk_sys), .arst_n_i(arst_n), .link_clk_i(lclk), .cs_n_i(cs_n),
    .io_i(h_io), .io_o(d_io), .io_oe_o(d_oe), .write_protect_n_i(wp_n), .quad_mode_i(quad),
    .factory_otp_lock_i(fact), .otp_mode_i(otp), .block_protect_level_i(lvl),
    .erase_result_valid_i(ev[7]), .erase_failed_i(ev[6]), .program_result_valid_i(ev[5]),
    .program_failed_i(ev[4]), .erase_suspend_i(ev[3]), .erase_resume_i(ev[2]),
    .program_suspend_i(ev[1]), .program_resume_i(ev[0]), .query_addr_i(qa), .query_protected_o(qp),
    .array_access_ok_o(aok), .otp_area1_writable_o(otpw), .write_enable_latch_o(write_enable_latch), .status_o(st));
  // A line the design does not drive shows the inverse, so a missing enable corrupts the answer.
  fps_host_model host_u (.link_clk_o(lclk), .cs_n_o(cs_n), .io_o(h_io), .io_i(d_io ~^ d_oe));
  // ----------------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // The run needs about 950 cycles, so 5000 means a hang.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One frame; the host already waits out the execution delay after deselect.
  task automatic go(input logic qd, input int nb, input logic [47:0] tx);
    host_u.xfer(qd, nb, tx, rx);
    @(posedge clk_sys) #1;
  endtask
  task automatic wgo(input int nb, input logic [47:0] tx);
    go(1'b0, 8, {WE, 40'h0});
    go(1'b0, nb, tx);
  endtask
  // Four edges cover the pin synchronisers and the registered answer.
  task automatic q(input logic [23:0] a, input logic e);
    qa = a;
    repeat (4) @(posedge clk_sys);
    #1 chk({7'h0, qp}, {7'h0, e});
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    arst_n = 1'b0; wp_n = 1'b1; quad = 1'b0; otp = 1'b0; lvl = 4'h0; ev = 8'h0; qa = 24'h0;
    fact = 1'b1;
    evt = '{16'hC043, 16'h8003, 16'h3023, 16'h2003, 16'h080B, 16'h0403, 16'h0207, 16'h0103, 16'h0C0B, 16'h0403};
    repeat (4) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk(st, 8'h01);
    chk({5'h0, write_enable_latch, otpw, aok}, 8'h03);
    go(1'b0, 8, {WS, 40'h0});
    chk(st, 8'h01);
    quad = 1'b1;
    go(1'b0, 24, {RS, 40'h0});
    chk(rx[39:32], 8'h01);
    chk(rx[31:24], 8'h01);
    go(1'b1, 24, {RS, 40'h0});
    chk(rx[39:32], 8'h01);
    quad = 1'b0;
    go(1'b1, 8, {WE, 40'h0});
    go(1'b0, 12, {WS, 40'h0});
    chk({6'h0, write_enable_latch, st[1]}, 8'h02);
    go(1'b0, 8, {WS, 40'h0});
    chk({write_enable_latch, otpw, st[5:0]}, 8'h03);
    foreach (evt[i]) begin
      ev = evt[i][15:8];
      @(posedge clk_sys) #1 ev = 8'h0;
      @(posedge clk_sys) #1 chk(st, evt[i][7:0]);
    end
    lvl = 4'h1;
    q(24'hFF0000, 1'b1);
    q(24'h000000, 1'b0);
    otp = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk({7'h0, aok}, 8'h00);
    otp = 1'b0;
    wgo(8, {SL, 40'h0});
    chk(st, 8'h83);
    q(24'h000000, 1'b1);
    go(1'b0, 48, {VR, 40'h0});
    chk(rx[7:0], 8'hFF);
    wgo(8, {8'h98, 40'h0});
    q(24'hFF0000, 1'b0);
    wgo(40, {VW, 24'h001000, 8'hFF, 8'h0});
    q(24'h001000, 1'b1);
    q(24'h000000, 1'b0);
    wp_n = 1'b0;
    q(24'h000000, 1'b1);
    wp_n = 1'b1;
    wgo(32, {PP, 24'h020000, 16'h0});
    q(24'h02FFFF, 1'b1);
    go(1'b0, 48, {PR, 24'h020000, 16'h0});
    chk(rx[7:0], 8'hFF);
    wgo(8, {PE, 40'h0});
    q(24'h020000, 1'b0);
    wgo(24, {LW, 8'hBF, 8'hFF, 24'h0});
    wgo(32, {PP, 24'h020000, 16'h0});
    q(24'h020000, 1'b0);
    chk({7'h0, write_enable_latch}, 8'h00);
    go(1'b0, 24, {8'h15, 40'h0});
    chk(rx[39:32], 8'hBF);
    chk(rx[31:24], 8'hFF);
    wgo(8, {8'h7E, 40'h0});
    q(24'hFF0000, 1'b1);
    chk(st, 8'h83);
    fact = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk(st, 8'h82);
    complete_run();
  end
endmodule
